/* File: design/drc_pkg.sv */
// package of constants for the drive run-command and dwell control block
`default_nettype none
package drc_pkg;
  // terminal function codes
  localparam logic [5:0] FN_RUN_PERMIT = 6'h0D;  // run-permit terminal
  localparam logic [5:0] FN_THREE_WIRE = 6'h0E;  // three-wire stop terminal
  // run-permit mode selection
  localparam logic       PERMIT_ALWAYS = 1'b0;
  localparam logic       PERMIT_DI     = 1'b1;
  // permit-loss stop modes
  localparam logic [1:0] STOP_COAST    = 2'h0;
  localparam logic [1:0] STOP_QSTOP    = 2'h1;
  localparam logic [1:0] STOP_QRESUME  = 2'h2;
  // control mode selection value that allows brake dwell
  localparam logic [1:0] CTRL_VF       = 2'h0;
  // clock and time base (settings in tenths of a second, freqs in 0.01 Hz)
  localparam int CLK_HZ            = 20_000_000;
  localparam int MIN_PRESS_US      = 1000;
  localparam int MIN_PRESS_CYC     = (CLK_HZ / 1_000_000) * MIN_PRESS_US;
  localparam int TENTH_SEC_CYC     = CLK_HZ / 10;
  // setting defaults and limits
  localparam logic [15:0] QSTOP_DEF_DS   = 16'h0032;  // 5.0 s
  localparam logic [15:0] QSTOP_MAX_DS   = 16'h1770;  // 600.0 s
  localparam logic [15:0] ACC_DW_F_DEF   = 16'h01F4;  // 5.00 Hz
  localparam logic [15:0] DEC_DW_F_DEF   = 16'h01F4;  // 5.00 Hz
  localparam logic [15:0] ACC_DW_T_MAX   = 16'h0064;  // 10.0 s
  localparam logic [15:0] DEC_DW_T_MAX   = 16'h0258;  // 60.0 s
  localparam logic [15:0] DWELL_T_DEF    = 16'h0000;  // 0.0 s
  // ramp phase states
  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_ACC_DW = 3'b001,
    PH_RUN    = 3'b010,
    PH_DEC_DW = 3'b011,
    PH_DEC    = 3'b100,
    PH_QSTOP  = 3'b101
  } drc_phase_t;
endpackage
`default_nettype wire

/* File: design/drc_run_ctrl.sv */
// run-command latching, run permit and dwell sequencing for a motor drive
`default_nettype none
// How it works
// - three-wire function latches a momentary run press until stopped.
// - forward and reverse pressed together stop the drive.
// - terminal function code 13 is the run-permit terminal.
// - permit mode 0 always permits; mode 1 follows the permit terminal.
// - stop mode 0 blocks output at once on permit loss (coast).
// - stop mode 1 quick-decelerates; restart needs a fresh run command.
// - stop mode 2 quick-decelerates; re-entered run resumes while permitted.
// - quick-stop time used only in modes 1 and 2, 5.0 s, 0-600 s.
// - run ramps to accel dwell freq, holds dwell time, then accelerates.
// - stop ramps to decel dwell freq, holds dwell time, then decelerates.
// - dwell skipped when its time or frequency is zero.
// - accel dwell only on first acceleration after a run command.
// - decel dwell only on stop decel, not reference change or brake control.
// - accel dwell freq default 5.00 Hz, time 0.0-10.0 s default 0.0.
// - decel dwell time up to 60.0 s default 0; freq default 5.00 Hz.
// - brake dwell available only in plain voltage-to-frequency control mode.
module drc_run_ctrl #(
  parameter int unsigned PRESS_CYC = drc_pkg::MIN_PRESS_CYC,  // 1 ms filter
  parameter int unsigned TICK_CYC  = drc_pkg::TENTH_SEC_CYC   // 0.1 s tick
) (
  input  wire logic        i_sys_clk,         // 20 MHz system clock
  input  wire logic        i_rst_n,           // synchronous reset, active low
  input  wire logic [5:0]  i_stop_fn,         // function select of stop terminal
  input  wire logic [5:0]  i_permit_fn,       // function select of permit terminal
  input  wire logic        i_forward_run_input, // forward push button / contact
  input  wire logic        i_reverse_run_input, // reverse push button / contact
  input  wire logic        i_stop_input,      // three-wire stop (active = run allowed)
  input  wire logic        i_permit_input,    // run-permit terminal
  input  wire logic        i_permit_mode,     // 0 always, 1 from terminal
  input  wire logic [1:0]  i_stop_mode,       // permit-loss stop mode
  input  wire logic [1:0]  i_ctrl_mode,       // control mode selection
  input  wire logic [15:0] i_qstop_ds,        // quick-stop time, 0.1 s
  input  wire logic [15:0] i_acc_dw_freq,     // accel dwell freq, 0.01 Hz
  input  wire logic [15:0] i_acc_dw_ds,       // accel dwell time, 0.1 s
  input  wire logic [15:0] i_dec_dw_freq,     // decel dwell freq, 0.01 Hz
  input  wire logic [15:0] i_dec_dw_ds,       // decel dwell time, 0.1 s
  input  wire logic [15:0] i_out_freq,        // ramp output frequency, 0.01 Hz
  input  wire logic        i_ref_decel,       // decel from reference change
  input  wire logic        i_ext_brake,       // external brake control active
  output logic             o_run_fwd,         // run forward request
  output logic             o_run_rev,         // run reverse request
  output logic             o_out_block,       // block drive output (coast)
  output logic             o_qstop,           // quick-decel request
  output logic [15:0]      o_qstop_ds,        // clamped quick-stop time
  output logic             o_ramp_hold,       // hold frequency (dwell)
  output logic [15:0]      o_freq_limit,      // dwell target, 0 = none
  output logic [2:0]       o_phase            // sequencer phase
);
  // ----------------------------------------
  // input qualification
  // ----------------------------------------
  logic              three_wire;
  logic              permit_ok;
  logic              fwd_ok;
  logic              rev_ok;
  logic [31:0]       fcnt_q;
  logic [31:0]       rcnt_q;
  logic              run_req;
  logic              dwell_en;
  assign three_wire = (i_stop_fn == drc_pkg::FN_THREE_WIRE);
  // permit terminal only counts when assigned code 13
  assign permit_ok  = (i_permit_mode == drc_pkg::PERMIT_ALWAYS) ||
                      ((i_permit_fn == drc_pkg::FN_RUN_PERMIT) && i_permit_input);
  assign dwell_en   = (i_ctrl_mode == drc_pkg::CTRL_VF);

  // press filters: a press counts once held PRESS_CYC - 1 cycles; glitches are ignored
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fcnt_q <= 32'h0000_0000;
      rcnt_q <= 32'h0000_0000;
    end else begin
      fcnt_q <= !i_forward_run_input ? 32'h0000_0000 :
                (fcnt_q < PRESS_CYC) ? fcnt_q + 32'h0000_0001 : fcnt_q;
      rcnt_q <= !i_reverse_run_input ? 32'h0000_0000 :
                (rcnt_q < PRESS_CYC) ? rcnt_q + 32'h0000_0001 : rcnt_q;
    end
  end
  assign fwd_ok = (fcnt_q >= PRESS_CYC - 1);
  assign rev_ok = (rcnt_q >= PRESS_CYC - 1);

  // ----------------------------------------
  // run latch
  // ----------------------------------------
  logic fwd_q;
  logic rev_q;
  logic lockout_q;     // set by permit loss with a latched run, in any stop mode, until run is re-entered
  logic cmd_q;         // previous raw command, for fresh-command edges
  logic cmd_now;
  assign cmd_now = fwd_ok ^ rev_ok;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
    end else if (fwd_ok && rev_ok) begin
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
    end else if (three_wire) begin
      if (!i_stop_input) begin
        fwd_q <= 1'b0;
        rev_q <= 1'b0;
      end else if (fwd_ok) begin
        fwd_q <= 1'b1;
        rev_q <= 1'b0;
      end else if (rev_ok) begin
        fwd_q <= 1'b0;
        rev_q <= 1'b1;
      end
    end else begin
      // two-wire: command follows the contacts
      fwd_q <= fwd_ok;
      rev_q <= rev_ok;
    end
  end
  assign run_req = (fwd_q || rev_q) && permit_ok && !lockout_q;

  // permit withdrawn under a ramped stop mode: every moving phase quick-decelerates,
  // not only steady running, so a loss during a dwell still uses the quick-stop time
  logic qs_req;
  assign qs_req = !permit_ok && (i_stop_mode != drc_pkg::STOP_COAST);

  // permit-loss lockout: every stop mode needs a freshly entered command
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      lockout_q <= 1'b0;
      cmd_q     <= 1'b0;
    end else begin
      cmd_q <= cmd_now;
      if (!permit_ok && (fwd_q || rev_q)) begin
        lockout_q <= 1'b1;
      end else if (permit_ok && cmd_now && !cmd_q) begin
        lockout_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // 0.1 s tick for dwell timing
  // ----------------------------------------
  logic [31:0] tdiv_q;
  logic        tick;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tdiv_q <= 32'h0000_0000;
    end else begin
      tdiv_q <= (tdiv_q >= TICK_CYC - 1) ? 32'h0000_0000 : tdiv_q + 32'h0000_0001;
    end
  end
  assign tick = (tdiv_q >= TICK_CYC - 1);

  // ----------------------------------------
  // dwell and stop sequencer
  // ----------------------------------------
  drc_pkg::drc_phase_t ph_q;
  logic [15:0] dw_cnt_q;
  logic        acc_done_q;  // first acceleration already dwelt
  logic        acc_skip;
  logic        dec_skip;
  logic [15:0] acc_t;
  logic [15:0] dec_t;
  logic [15:0] qs_t;
  assign acc_t = (i_acc_dw_ds > drc_pkg::ACC_DW_T_MAX) ? drc_pkg::ACC_DW_T_MAX : i_acc_dw_ds;
  assign dec_t = (i_dec_dw_ds > drc_pkg::DEC_DW_T_MAX) ? drc_pkg::DEC_DW_T_MAX : i_dec_dw_ds;
  assign qs_t  = (i_qstop_ds > drc_pkg::QSTOP_MAX_DS) ? drc_pkg::QSTOP_MAX_DS : i_qstop_ds;
  assign acc_skip = (acc_t == 16'h0000) || (i_acc_dw_freq == 16'h0000)
                    || !dwell_en || acc_done_q;
  assign dec_skip = (dec_t == 16'h0000) || (i_dec_dw_freq == 16'h0000)
                    || !dwell_en || i_ext_brake || i_ref_decel;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ph_q       <= drc_pkg::PH_IDLE;
      dw_cnt_q   <= 16'h0000;
      acc_done_q <= 1'b0;
    end else begin
      case (ph_q)
        drc_pkg::PH_IDLE: begin
          dw_cnt_q <= 16'h0000;
          if (run_req) begin
            ph_q <= acc_skip ? drc_pkg::PH_RUN : drc_pkg::PH_ACC_DW;
          end
        end
        drc_pkg::PH_ACC_DW: begin
          if (qs_req) begin
            ph_q       <= drc_pkg::PH_QSTOP;
            acc_done_q <= 1'b1;
          end else if (!run_req) begin
            ph_q       <= drc_pkg::PH_DEC;
            acc_done_q <= 1'b1;
          end else if (i_out_freq >= i_acc_dw_freq) begin
            if (tick) dw_cnt_q <= dw_cnt_q + 16'h0001;
            if (dw_cnt_q >= acc_t) begin
              ph_q       <= drc_pkg::PH_RUN;
              acc_done_q <= 1'b1;
            end
          end
        end
        drc_pkg::PH_RUN: begin
          acc_done_q <= 1'b1;
          dw_cnt_q   <= 16'h0000;
          if (qs_req) begin
            ph_q <= drc_pkg::PH_QSTOP;
          end else if (!run_req) begin
            ph_q <= dec_skip ? drc_pkg::PH_DEC : drc_pkg::PH_DEC_DW;
          end
        end
        drc_pkg::PH_DEC_DW: begin
          if (run_req) begin
            ph_q <= drc_pkg::PH_RUN;
          end else if (qs_req) begin
            ph_q <= drc_pkg::PH_QSTOP;
          end else if (i_out_freq <= i_dec_dw_freq) begin
            if (tick) dw_cnt_q <= dw_cnt_q + 16'h0001;
            if (dw_cnt_q >= dec_t) ph_q <= drc_pkg::PH_DEC;
          end
        end
        drc_pkg::PH_DEC, drc_pkg::PH_QSTOP: begin
          if (run_req) begin
            ph_q <= drc_pkg::PH_RUN;
          end else if (i_out_freq == 16'h0000) begin
            ph_q       <= drc_pkg::PH_IDLE;
            acc_done_q <= 1'b0;  // next run command may dwell again
          end else if (qs_req) begin
            ph_q <= drc_pkg::PH_QSTOP;  // permit lost during a normal stop: finish quickly
          end
        end
        default: ph_q <= drc_pkg::PH_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_run_fwd    <= 1'b0;
      o_run_rev    <= 1'b0;
      o_out_block  <= 1'b0;
      o_qstop      <= 1'b0;
      o_qstop_ds   <= drc_pkg::QSTOP_DEF_DS;
      o_ramp_hold  <= 1'b0;
      o_freq_limit <= 16'h0000;
      o_phase      <= 3'b000;
    end else begin
      o_run_fwd    <= run_req && fwd_q;
      o_run_rev    <= run_req && rev_q;
      // coast blocks at once; the ramp generator is bypassed
      o_out_block  <= !permit_ok && (i_stop_mode == drc_pkg::STOP_COAST);
      o_qstop      <= (ph_q == drc_pkg::PH_QSTOP);
      o_qstop_ds   <= qs_t;
      o_ramp_hold  <= ((ph_q == drc_pkg::PH_ACC_DW) && (i_out_freq >= i_acc_dw_freq)) ||
                      ((ph_q == drc_pkg::PH_DEC_DW) && (i_out_freq <= i_dec_dw_freq));
      o_freq_limit <= (ph_q == drc_pkg::PH_ACC_DW) ? i_acc_dw_freq :
                      (ph_q == drc_pkg::PH_DEC_DW) ? i_dec_dw_freq :
                      16'h0000;
      o_phase      <= ph_q;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_both_stop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (fwd_ok && rev_ok) |=> !fwd_q && !rev_q)
    else $error("simultaneous forward and reverse did not stop");
  chk_stop_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (three_wire && !i_stop_input) |=> ##1 !o_run_fwd && !o_run_rev)
    else $error("stop input did not clear run");
  chk_coast_block: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!permit_ok && i_stop_mode == drc_pkg::STOP_COAST) |=> o_out_block)
    else $error("coast stop did not block output");
  chk_qstop_mode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_qstop |-> $past(i_stop_mode) != drc_pkg::STOP_COAST)
    else $error("quick stop in coast mode");
  chk_latch_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (three_wire && i_stop_input && fwd_q && !rev_ok) |=> fwd_q)
    else $error("three-wire latch lost");
  chk_acc_skip: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (ph_q == drc_pkg::PH_IDLE && run_req && acc_skip) |=> ph_q == drc_pkg::PH_RUN)
    else $error("dwell not skipped");
  chk_dec_brake: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (ph_q == drc_pkg::PH_RUN && permit_ok && !run_req && i_ext_brake)
      |=> ph_q != drc_pkg::PH_DEC_DW)
    else $error("decel dwell under brake control");
  chk_lockout: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    lockout_q && !(cmd_now && !cmd_q) |=> !o_run_fwd && !o_run_rev)
    else $error("restart without fresh command");
  chk_vf_only: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ctrl_mode != drc_pkg::CTRL_VF) |-> ph_q != drc_pkg::PH_ACC_DW || acc_done_q
      || $past(i_ctrl_mode) == drc_pkg::CTRL_VF)
    else $error("dwell outside v/f mode");
  // a withdrawn permit in modes 1 and 2 must reach the quick-stop phase from any motion
  chk_qstop_enter: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (qs_req && ph_q != drc_pkg::PH_IDLE && i_out_freq != 16'h0000) |=> ph_q == drc_pkg::PH_QSTOP)
    else $error("permit loss did not quick-stop");
  chk_permit_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !permit_ok |=> !o_run_fwd && !o_run_rev)
    else $error("run request without permit");
endmodule
`default_nettype wire

/* File: bench/drc_btn_model.sv */
// push-button partner model: stretches each tap into a held press
`default_nettype none
module drc_btn_model #(
  parameter int unsigned HOLD_CYC = 6  // press length in clock cycles
) (
  input  wire logic i_sys_clk,  // system clock
  input  wire logic i_fwd_tap,  // one-cycle forward request from the bench
  input  wire logic i_rev_tap,  // one-cycle reverse request from the bench
  output logic      o_fwd,      // forward contact level
  output logic      o_rev       // reverse contact level
);
  int unsigned fwd_cnt = 0;
  int unsigned rev_cnt = 0;
  // a human press always outlasts the input filter, so hold it long enough
  always_ff @(posedge i_sys_clk) begin
    fwd_cnt <= i_fwd_tap ? HOLD_CYC : (fwd_cnt != 0 ? fwd_cnt - 1 : 0);
    rev_cnt <= i_rev_tap ? HOLD_CYC : (rev_cnt != 0 ? rev_cnt - 1 : 0);
  end
  assign o_fwd = (fwd_cnt != 0);
  assign o_rev = (rev_cnt != 0);
endmodule
`default_nettype wire

/* File: bench/test_drive_run_command_dwell_control.sv */
// self-checking bench for the run-command and dwell control block
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_drive_run_command_dwell_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 4;   // shortened press filter
  localparam int TC = 10;  // shortened 0.1 s tick
  logic clk = 1'b0, rst_n = 1'b0, fwd_tap = 1'b0, rev_tap = 1'b0, fwd_ln, rev_ln;
  logic [5:0] stop_fn = 6'h0E, permit_fn = 6'h00;
  logic stop_in = 1'b1, permit_in = 1'b1, permit_mode = 1'b0, ref_decel = 1'b0;
  logic ext_brake = 1'b0;
  logic [1:0] stop_mode = 2'h0, ctrl_mode = 2'h0;
  logic [15:0] qstop_set = 16'h0032, acc_f = 16'h01F4, acc_ds = 16'h0000;
  logic [15:0] dec_f = 16'h01F4, dec_ds = 16'h0000, out_freq = 16'h0000;
  logic run_fwd, run_rev, out_block, qstop, ramp_hold;
  logic [15:0] qstop_ds, freq_limit;
  logic [2:0] phase;
  int bad_count = 0, n_compared = 0, n, m;
  logic [15:0] vals[$];
  logic seen;
  always #25 clk = ~clk;
  drc_btn_model #(.HOLD_CYC(PC + 2)) drc_btn_model_inst (.i_sys_clk(clk), .i_fwd_tap(fwd_tap),
    .i_rev_tap(rev_tap), .o_fwd(fwd_ln), .o_rev(rev_ln));
  drc_run_ctrl #(.PRESS_CYC(PC), .TICK_CYC(TC)) drc_run_ctrl_inst (.i_sys_clk(clk),
    .i_rst_n(rst_n), .i_stop_fn(stop_fn), .i_permit_fn(permit_fn), .i_forward_run_input(fwd_ln),
    .i_reverse_run_input(rev_ln), .i_stop_input(stop_in), .i_permit_input(permit_in),
    .i_permit_mode(permit_mode), .i_stop_mode(stop_mode), .i_ctrl_mode(ctrl_mode),
    .i_qstop_ds(qstop_set), .i_acc_dw_freq(acc_f), .i_acc_dw_ds(acc_ds), .i_dec_dw_freq(dec_f),
    .i_dec_dw_ds(dec_ds), .i_out_freq(out_freq), .i_ref_decel(ref_decel),
    .i_ext_brake(ext_brake), .o_run_fwd(run_fwd), .o_run_rev(run_rev), .o_out_block(out_block),
    .o_qstop(qstop), .o_qstop_ds(qstop_ds), .o_ramp_hold(ramp_hold), .o_freq_limit(freq_limit),
    .o_phase(phase));
  // reference model of the permit block and quick-stop clamp, compared every cycle
  logic model_on = 1'b0, exp_block = 1'b0;
  int exp_qs = 50;
  always @(posedge clk) begin
    if (model_on) begin
      `CHK("out_block model", exp_block, out_block)
      `CHK("qstop_ds model", exp_qs[15:0], qstop_ds)
    end
    model_on <= 1'b1;
    exp_block <= rst_n && permit_mode && !(permit_fn == 6'h0D && permit_in)
                 && (stop_mode == 2'h0);
    exp_qs <= !rst_n ? 50 : (int'(qstop_set) > 6000) ? 6000 : int'(qstop_set);
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // sample a little after the edge so registered outputs have settled
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic tap(logic f, logic r);
    @(posedge clk);
    fwd_tap <= f;
    rev_tap <= r;
    @(posedge clk);
    fwd_tap <= 1'b0;
    rev_tap <= 1'b0;
    #1;
  endtask
  // bounded wait on the phase; running out ends the run
  task automatic wait_for(logic [2:0] ph, string nm);
    int k;
    for (k = 0; k < 300 && phase !== ph; k++) cyc(1);
    if (phase !== ph) begin
      `CHK(nm, ph, phase)
      tally_and_finish();
    end
  endtask
  task automatic to_idle;
    @(posedge clk);
    stop_in <= 1'b0;
    out_freq <= 16'h0000;
    wait_for(3'd0, "idle");
    @(posedge clk);
    stop_in <= 1'b1;
    #1;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(97895));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    `CHK("qstop_ds reset", 16'h0032, qstop_ds)
    // latch survives release, no dwell with zero times
    tap(1'b1, 1'b0);
    wait_for(3'd2, "run");
    cyc(2 * PC);
    `CHK("fwd latched", 1'b1, run_fwd)
    @(posedge clk);
    stop_in <= 1'b0;
    cyc(4);
    `CHK("fwd after stop", 1'b0, run_fwd)
    tap(1'b1, 1'b0);
    cyc(2 * PC + 4);
    `CHK("press while stopped", 1'b0, run_fwd)
    to_idle();
    tap(1'b0, 1'b1);
    wait_for(3'd2, "run rev");
    `CHK("rev latched", 1'b1, run_rev)
    tap(1'b1, 1'b1);
    cyc(2 * PC + 4);
    `CHK("both fwd", 1'b0, run_fwd)
    `CHK("both rev", 1'b0, run_rev)
    to_idle();
    $display("test three_wire done");
    // accel and decel dwell, then re-run during decel
    @(posedge clk);
    acc_ds <= 16'h0003;
    dec_ds <= 16'h0002;
    out_freq <= 16'h01F4;
    tap(1'b1, 1'b0);
    wait_for(3'd1, "acc dwell");
    `CHK("acc target", 16'h01F4, freq_limit)
    seen = 1'b0;
    for (n = 0; n < 500 && phase === 3'd1; n++) begin
      cyc(1);
      seen = seen | (ramp_hold === 1'b1);
    end
    `CHK("acc hold", 1'b1, seen)
    `CHK("acc time", 1'b1, n >= 2 * TC && n <= 4 * TC)
    @(posedge clk);
    stop_in <= 1'b0;
    wait_for(3'd3, "dec dwell");
    `CHK("dec target", 16'h01F4, freq_limit)
    for (n = 0; n < 500 && phase === 3'd3; n++) cyc(1);
    `CHK("dec time", 1'b1, n >= TC && n <= 3 * TC)
    `CHK("after dec dwell", 3'd4, phase)
    @(posedge clk);
    stop_in <= 1'b1;
    tap(1'b1, 1'b0);
    cyc(2 * PC + 4);
    `CHK("re-run no dwell", 3'd2, phase)
    to_idle();
    // brake control and reference change suppress the decel dwell
    @(posedge clk);
    acc_ds <= 16'h0000;
    for (m = 0; m < 2; m++) begin
      tap(1'b1, 1'b0);
      wait_for(3'd2, "run");
      @(posedge clk);
      out_freq <= 16'h01F4;
      ext_brake <= (m == 0);
      ref_decel <= (m == 1);
      stop_in <= 1'b0;
      cyc(8);
      `CHK("no dec dwell", 3'd4, phase)
      to_idle();
    end
    // dwell skipped outside plain V/F mode or with zero dwell freq
    @(posedge clk);
    ext_brake <= 1'b0;
    ref_decel <= 1'b0;
    acc_ds <= 16'h0003;
    for (m = 0; m < 2; m++) begin
      @(posedge clk);
      ctrl_mode <= (m == 0) ? 2'h1 : 2'h0;
      acc_f <= (m == 0) ? 16'h01F4 : 16'h0000;
      out_freq <= 16'h01F4;
      tap(1'b1, 1'b0);
      cyc(2 * PC + 6);
      `CHK("dwell skipped", 3'd2, phase)
      to_idle();
    end
    @(posedge clk);
    acc_ds <= 16'h0000;
    $display("test dwell done");
    // run permit in every stop mode
    permit_fn <= 6'h0D;
    permit_mode <= 1'b1;
    for (m = 0; m < 3; m++) begin
      @(posedge clk);
      stop_mode <= m[1:0];
      out_freq <= 16'h01F4;
      tap(1'b1, 1'b0);
      wait_for(3'd2, "permit run");
      @(posedge clk);
      permit_in <= 1'b0;
      cyc(6);
      if (m == 0) `CHK("coast", 1'b1, out_block)
      else begin
        `CHK("qstop", 1'b1, qstop)
        `CHK("qstop phase", 3'd5, phase)
      end
      @(posedge clk);
      out_freq <= 16'h0000;
      wait_for(3'd0, "stopped");
      @(posedge clk);
      permit_in <= 1'b1;
      cyc(2 * PC + 4);
      `CHK("no restart", 1'b0, run_fwd)
      tap(1'b1, 1'b0);
      wait_for(3'd2, "resume");
      `CHK("resume fwd", 1'b1, run_fwd)
      to_idle();
    end
    // a terminal with another function code is no permit
    @(posedge clk);
    permit_fn <= 6'h0C;
    tap(1'b1, 1'b0);
    cyc(2 * PC + 4);
    `CHK("foreign code", 1'b0, run_fwd)
    to_idle();
    @(posedge clk);
    permit_mode <= 1'b0;
    permit_in <= 1'b0;
    tap(1'b1, 1'b0);
    wait_for(3'd2, "always permit");
    `CHK("always permit", 1'b1, run_fwd)
    to_idle();
    $display("test permit done");
    // quick-stop time clamp, boundaries and random settings
    vals = {16'hFFFF, 16'h1770, 16'h1771, 16'h0000};
    repeat (4) vals.push_back(16'($urandom % 7000));
    foreach (vals[i]) begin
      @(posedge clk);
      qstop_set <= vals[i];
      cyc(3);
      `CHK("qstop clamp", (vals[i] > 16'h1770) ? 16'h1770 : vals[i], qstop_ds)
    end
    $display("test qstop done");
    // reset while idle brings the quick-stop time back to its default
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(1);
    `CHK("qstop_ds in reset", 16'h0032, qstop_ds)
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
